/* File: tb/afe_serial_sample_port_test.sv */
`timescale 1ns/1ps
module afe_serial_sample_port_test;
  logic clock_i = 1'b0;
  logic reset_n_i;
  logic [9:0] adc;
  logic energy;
  logic gain;
  logic [2:0] stb;
  logic [1:0] sclk;
  logic [1:0] sen;
  logic [1:0] sdat;
  logic [3:0] pulse;
  assp_pkg::assp_rx_word_type rx_word;
  logic [9:0] tx_dac;
  assp_pkg::assp_eye_pair_type eye_out;
  logic [4:0][9:0] ctrl;
  int pulses [4] = '{0, 0, 0, 0};
  int num_errors = 0;
  int checked = 0;
  always #4 clock_i = ~clock_i;
  assp_dsp_model dsp_u (
    .clock_i(clock_i),
    .strobe_o(stb),
    .shift_clock_o(sclk),
    .write_enable_o(sen),
    .serial_o(sdat)
  );
  assp_top dut_u (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .receive_sample_strobe_i(stb[0]),
    .transmit_sample_strobe_i(stb[1]),
    .eye_sample_strobe_i(stb[2]),
    .main_shift_clock_i(sclk[0]),
    .main_write_enable_i(sen[0]),
    .main_serial_input_i(sdat[0]),
    .eye_shift_clock_i(sclk[1]),
    .eye_write_enable_i(sen[1]),
    .eye_serial_input_i(sdat[1]),
    .adc_result_i(adc),
    .energy_flag_i(energy),
    .gain_ack_flag_i(gain),
    .rx_convert_o(pulse[0]),
    .rx_out_load_o(pulse[3]),
    .rx_out_word_o(rx_word),
    .tx_convert_o(pulse[1]),
    .tx_dac_o(tx_dac),
    .eye_convert_o(pulse[2]),
    .eye_out_o(eye_out),
    .ctrl_reg_o(ctrl)
  );
  // pulses are one cycle wide, so count them rather than catch them
  always @(posedge clock_i) begin
    for (int k = 0; k < 4; k++) begin
      if (pulse[k] === 1'b1) begin
        pulses[k]++;
      end
    end
  end
  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // destination lands 3..4 cycles after the word; 8 gives margin
  task automatic settle();
    repeat (8) @(posedge clock_i);
    #1;
  endtask
  initial begin
    #100us;
    num_errors++;
    print_verdict();
  end
  initial begin
    reset_n_i = 1'b0;
    adc = 10'h000;
    energy = 1'b0;
    gain = 1'b0;
    repeat (10) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    dsp_u.send_word(0, {6'h00, 10'h2a5}, 1'b1);
    settle();
    dsp_u.strobe(1);
    check("tx_dac first", 20'h0, 20'(tx_dac));
    dsp_u.strobe(1);
    check("tx_dac", 20'h2a5, 20'(tx_dac));
    check("tx pulses", 20'h2, 20'(pulses[1]));
    for (int d = 3; d < 8; d++) begin
      dsp_u.send_word(0, {3'(d), 3'h0, 10'(d * 37)}, 1'b1);
    end
    dsp_u.send_word(0, {6'h18, 10'h3ff}, 1'b0);
    settle();
    for (int d = 3; d < 8; d++) begin
      check("ctrl", 20'(d * 37), 20'(ctrl[d - 3]));
    end
    dsp_u.send_word(0, {6'h08, 10'h111}, 1'b1);
    dsp_u.send_word(0, {6'h10, 10'h222}, 1'b1);
    settle();
    dsp_u.strobe(2);
    dsp_u.strobe(2);
    check("eye main", {10'h111, 10'h222}, eye_out);
    dsp_u.send_word(1, {6'h02, 10'h155}, 1'b1);
    dsp_u.send_word(1, {6'h04, 10'h0aa}, 1'b1);
    dsp_u.send_word(1, {6'h00, 10'h3c3}, 1'b1);
    dsp_u.send_word(1, {6'h06, 10'h0f0}, 1'b1);
    dsp_u.send_word(1, {6'h02, 10'h001}, 1'b0);
    settle();
    dsp_u.strobe(2);
    check("eye early", {10'h111, 10'h222}, eye_out);
    dsp_u.strobe(2);
    check("eye pair", {10'h155, 10'h0aa}, eye_out);
    check("eye pulses", 20'h4, 20'(pulses[2]));
    adc = 10'h1e7;
    dsp_u.strobe(0);
    check("rx first load", 20'h0, 20'(pulses[3]));
    @(posedge clock_i);
    #1;
    adc = 10'h019;
    energy = 1'b1;
    gain = 1'b1;
    dsp_u.strobe(0);
    check("rx word", {8'h0, 2'h3, 10'h1e7}, 20'(rx_word));
    check("rx pulses", 20'h2, 20'(pulses[0]));
    check("rx loads", 20'h1, 20'(pulses[3]));
    print_verdict();
  end
endmodule

/* File: tb/assp_dsp_model.sv */
`timescale 1ns/1ps
module assp_dsp_model (
  input wire logic clock_i,
  output logic [2:0] strobe_o,
  output logic [1:0] shift_clock_o,
  output logic [1:0] write_enable_o,
  output logic [1:0] serial_o
);
  initial begin
    strobe_o = 3'h0;
    shift_clock_o = 2'h0;
    write_enable_o = 2'h0;
    serial_o = 2'h0;
  end
  // port 0 main, 1 eye; link clock stands still between words
  task automatic send_word(input int p, input logic [15:0] word, input logic en);
    for (int b = 15; b >= 0; b--) begin
      write_enable_o[p] = en;
      serial_o[p] = word[b];
      #24 shift_clock_o[p] = 1'b1;
      #24 shift_clock_o[p] = 1'b0;
    end
    write_enable_o[p] = 1'b0;
    serial_o[p] = ~word[0];
    // gap keeps the next word's enable out of this time step
    #24;
  endtask
  // strobe period shortened far below the sample rate to keep the run short
  task automatic strobe(input int k);
    @(posedge clock_i);
    #1 strobe_o[k] = 1'b1;
    repeat (12) @(posedge clock_i);
    #1 strobe_o[k] = 1'b0;
    repeat (12) @(posedge clock_i);
    #1;
  endtask
endmodule

/* File: verilog/assp_pkg.sv */
package assp_pkg;

  localparam int WORD_W = 16;
  localparam int DATA_W = 10;
  localparam int CTRL_COUNT = 5;
  localparam int BIT_COUNT_W = 4;

  // main-port word: destination field and payload
  localparam int DEST_LSB = 13;
  localparam int DEST_W = 3;
  localparam logic [2:0] DEST_TX = 3'h0;
  localparam logic [2:0] DEST_EYE_X = 3'h1;
  localparam logic [2:0] DEST_EYE_Y = 3'h2;
  localparam logic [2:0] DEST_CTRL_BASE = 3'h3;

  // eye-port word: select field at bits 12..11
  localparam int EYE_SEL_LSB = 11;
  localparam int EYE_SEL_W = 2;
  localparam logic [1:0] EYE_SEL_X = 2'h1;
  localparam logic [1:0] EYE_SEL_Y = 2'h2;

  // strobe indices in the synchroniser vector
  localparam int STB_RX = 0;
  localparam int STB_TX = 1;
  localparam int STB_EYE = 2;
  localparam int STB_COUNT = 3;

  // converter latency in strobe cycles, and strobe rate in kHz
  localparam int DAC_LATENCY_STROBES = 2;
  localparam real STROBE_RATE_KHZ = 9.6;

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 10'h000;
  localparam logic [BIT_COUNT_W-1:0] LAST_BIT = 4'hf;

  typedef enum logic {
    ASSP_RX_EMPTY = 1'b0,
    ASSP_RX_PRIMED = 1'b1
  } assp_rx_state_type;

  typedef struct packed {
    logic gain_ack;
    logic energy;
    logic [DATA_W-1:0] result;
  } assp_rx_word_type;

  typedef struct packed {
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] y;
  } assp_eye_pair_type;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [BIT_COUNT_W-1:0] count;
    logic [WORD_W-1:0] word;
    logic toggle;
  } assp_port_state_type;

  typedef struct packed {
    logic [STB_COUNT-1:0] stb_s1;
    logic [STB_COUNT-1:0] stb_s2;
    logic [STB_COUNT-1:0] stb_s3;
    logic [1:0] tog_s1;
    logic [1:0] tog_s2;
    logic [1:0] tog_s3;
    assp_rx_state_type rx_state;
    logic [DATA_W-1:0] rx_result;
    assp_rx_word_type rx_out;
    logic rx_load;
    logic rx_conv;
    logic [DATA_W-1:0] tx_loaded;
    logic [DATA_W-1:0] tx_stage;
    logic [DATA_W-1:0] tx_dac;
    logic tx_conv;
    assp_eye_pair_type eye_loaded;
    assp_eye_pair_type eye_stage;
    assp_eye_pair_type eye_out;
    logic eye_conv;
    logic [CTRL_COUNT-1:0][DATA_W-1:0] ctrl;
  } assp_top_state_type;

  function automatic logic [DATA_W-1:0] payload(input logic [WORD_W-1:0] word);
    payload = word[DATA_W-1:0];
  endfunction

endpackage

/* File: verilog/assp_shift_port.sv */
`timescale 1ns/1ps
module assp_shift_port (
  input wire logic shift_clock_i,
  input wire logic reset_n_i,
  input wire logic write_enable_i,
  input wire logic serial_i,
  output logic [assp_pkg::WORD_W-1:0] word_o,
  output logic toggle_o
);

  assp_pkg::assp_port_state_type q;
  assp_pkg::assp_port_state_type next_q;

  // runs on the link clock; enable is launched by the same clock, so no sync
  always_comb begin
    next_q = q;
    if (write_enable_i) begin
      next_q.shift = {q.shift[assp_pkg::WORD_W-2:0], serial_i};
      next_q.count = q.count + 4'h1;
      if (q.count == assp_pkg::LAST_BIT) begin
        // word held until the next one completes, long enough to cross
        next_q.word = {q.shift[assp_pkg::WORD_W-2:0], serial_i};
        next_q.toggle = ~q.toggle;
      end
    end
  end

  always_ff @(posedge shift_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign word_o = q.word;
  assign toggle_o = q.toggle;

  a_shift_hold: assert property (@(posedge shift_clock_i) disable iff (!reset_n_i)
    !write_enable_i |=> $stable(q.shift) && $stable(q.word) && $stable(q.toggle))
    else $error("shift state changed while write enable low");

  a_word_done: assert property (@(posedge shift_clock_i) disable iff (!reset_n_i)
    write_enable_i && q.count == assp_pkg::LAST_BIT
    |=> q.word == {$past(q.shift[assp_pkg::WORD_W-2:0]), $past(serial_i)} && q.toggle != $past(q.toggle))
    else $error("sixteenth bit did not complete the word");

  a_shift_move: assert property (@(posedge shift_clock_i) disable iff (!reset_n_i)
    write_enable_i |=> q.shift[0] == $past(serial_i) && q.count == $past(q.count) + 4'h1)
    else $error("enabled edge did not shift one bit");

endmodule

/* File: verilog/assp_top.sv */
`timescale 1ns/1ps
module assp_top (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic receive_sample_strobe_i,
  input wire logic transmit_sample_strobe_i,
  input wire logic eye_sample_strobe_i,
  input wire logic main_shift_clock_i,
  input wire logic main_write_enable_i,
  input wire logic main_serial_input_i,
  input wire logic eye_shift_clock_i,
  input wire logic eye_write_enable_i,
  input wire logic eye_serial_input_i,
  input wire logic [assp_pkg::DATA_W-1:0] adc_result_i,
  input wire logic energy_flag_i,
  input wire logic gain_ack_flag_i,
  output logic rx_convert_o,
  output logic rx_out_load_o,
  output assp_pkg::assp_rx_word_type rx_out_word_o,
  output logic tx_convert_o,
  output logic [assp_pkg::DATA_W-1:0] tx_dac_o,
  output logic eye_convert_o,
  output assp_pkg::assp_eye_pair_type eye_out_o,
  output logic [assp_pkg::CTRL_COUNT-1:0][assp_pkg::DATA_W-1:0] ctrl_reg_o
);

  logic [1:0] reset_q;
  logic reset_sync_n;
  logic [assp_pkg::WORD_W-1:0] main_word;
  logic [assp_pkg::WORD_W-1:0] eye_word;
  logic main_toggle;
  logic eye_toggle;
  logic [assp_pkg::STB_COUNT-1:0] stb_rise;
  logic main_new;
  logic eye_new;
  logic [assp_pkg::DEST_W-1:0] main_dest;
  logic [assp_pkg::EYE_SEL_W-1:0] eye_sel;
  assp_pkg::assp_top_state_type q;
  assp_pkg::assp_top_state_type next_q;

  // async assert, released through two flops
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_q <= 2'h0;
    end else begin
      reset_q <= {reset_q[0], 1'b1};
    end
  end
  assign reset_sync_n = reset_q[1];

  // link side uses the raw reset: its clock may be stopped at release
  assp_shift_port main_port (
    .shift_clock_i(main_shift_clock_i),
    .reset_n_i(reset_n_i),
    .write_enable_i(main_write_enable_i),
    .serial_i(main_serial_input_i),
    .word_o(main_word),
    .toggle_o(main_toggle)
  );

  assp_shift_port eye_port (
    .shift_clock_i(eye_shift_clock_i),
    .reset_n_i(reset_n_i),
    .write_enable_i(eye_write_enable_i),
    .serial_i(eye_serial_input_i),
    .word_o(eye_word),
    .toggle_o(eye_toggle)
  );

  // edges seen on the second sync stage only
  assign stb_rise = q.stb_s2 & ~q.stb_s3;
  assign main_new = q.tog_s2[0] ^ q.tog_s3[0];
  assign eye_new = q.tog_s2[1] ^ q.tog_s3[1];
  assign main_dest = main_word[assp_pkg::DEST_LSB +: assp_pkg::DEST_W];
  assign eye_sel = eye_word[assp_pkg::EYE_SEL_LSB +: assp_pkg::EYE_SEL_W];

  always_comb begin
    next_q = q;
    next_q.stb_s1 = {eye_sample_strobe_i, transmit_sample_strobe_i, receive_sample_strobe_i};
    next_q.stb_s2 = q.stb_s1;
    next_q.stb_s3 = q.stb_s2;
    next_q.tog_s1 = {eye_toggle, main_toggle};
    next_q.tog_s2 = q.tog_s1;
    next_q.tog_s3 = q.tog_s2;
    next_q.rx_load = 1'b0;
    next_q.rx_conv = 1'b0;
    next_q.tx_conv = 1'b0;
    next_q.eye_conv = 1'b0;

    // word is stable for many link bits after its toggle flips
    if (main_new) begin
      case (main_dest)
        assp_pkg::DEST_TX: next_q.tx_loaded = assp_pkg::payload(main_word);
        assp_pkg::DEST_EYE_X: next_q.eye_loaded.x = assp_pkg::payload(main_word);
        assp_pkg::DEST_EYE_Y: next_q.eye_loaded.y = assp_pkg::payload(main_word);
        default: begin
          next_q.ctrl[main_dest - assp_pkg::DEST_CTRL_BASE] = assp_pkg::payload(main_word);
        end
      endcase
    end
    if (eye_new) begin
      case (eye_sel)
        assp_pkg::EYE_SEL_X: next_q.eye_loaded.x = assp_pkg::payload(eye_word);
        assp_pkg::EYE_SEL_Y: next_q.eye_loaded.y = assp_pkg::payload(eye_word);
        // select 00 and 11 are ignored; a main-port write this cycle must survive
        default: begin
        end
      endcase
    end

    if (stb_rise[assp_pkg::STB_RX]) begin
      next_q.rx_conv = 1'b1;
      next_q.rx_result = adc_result_i;
      case (q.rx_state)
        assp_pkg::ASSP_RX_EMPTY: next_q.rx_state = assp_pkg::ASSP_RX_PRIMED;
        assp_pkg::ASSP_RX_PRIMED: begin
          next_q.rx_load = 1'b1;
          next_q.rx_out = '{gain_ack: gain_ack_flag_i, energy: energy_flag_i,
                            result: q.rx_result};
        end
        default: next_q.rx_state = assp_pkg::ASSP_RX_EMPTY;
      endcase
    end

    // two-stage pipe gives the two-strobe latency
    if (stb_rise[assp_pkg::STB_TX]) begin
      next_q.tx_conv = 1'b1;
      next_q.tx_stage = q.tx_loaded;
      next_q.tx_dac = q.tx_stage;
    end
    if (stb_rise[assp_pkg::STB_EYE]) begin
      next_q.eye_conv = 1'b1;
      next_q.eye_stage = q.eye_loaded;
      next_q.eye_out = q.eye_stage;
    end
  end

  always_ff @(posedge clock_i or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rx_convert_o = q.rx_conv;
  assign rx_out_load_o = q.rx_load;
  assign rx_out_word_o = q.rx_out;
  assign tx_convert_o = q.tx_conv;
  assign tx_dac_o = q.tx_dac;
  assign eye_convert_o = q.eye_conv;
  assign eye_out_o = q.eye_out;
  assign ctrl_reg_o = q.ctrl;

  a_rx_conv_start: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    q.stb_s2[assp_pkg::STB_RX] && !q.stb_s3[assp_pkg::STB_RX] |=> rx_convert_o)
    else $error("receive strobe rise did not start conversion");

  a_rx_load_prev: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    rx_out_load_o |-> rx_convert_o && rx_out_word_o.result == $past(q.rx_result))
    else $error("loaded word is not the previous conversion");

  a_rx_word_flags: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    rx_out_load_o |-> rx_out_word_o.energy == $past(energy_flag_i)
      && rx_out_word_o.gain_ack == $past(gain_ack_flag_i))
    else $error("output word flags misplaced");

  a_tx_conv_start: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    q.stb_s2[assp_pkg::STB_TX] && !q.stb_s3[assp_pkg::STB_TX] |=> tx_convert_o)
    else $error("transmit strobe rise did not start conversion");

  a_tx_two_strobes: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    tx_convert_o |-> tx_dac_o == $past(q.tx_stage) && q.tx_stage == $past(q.tx_loaded))
    else $error("transmit output not two strobes behind load");

  a_tx_dac_hold: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !tx_convert_o |-> $stable(tx_dac_o))
    else $error("transmit output moved without strobe");

  a_dest_decode: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest == assp_pkg::DEST_TX
    |=> q.tx_loaded == $past(main_word[assp_pkg::DATA_W-1:0]))
    else $error("transmit destination not decoded");

  a_eye_select: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    eye_new && eye_sel == assp_pkg::EYE_SEL_Y && !main_new
    |=> q.eye_loaded.y == $past(eye_word[assp_pkg::DATA_W-1:0]) && $stable(q.eye_loaded.x))
    else $error("eye select did not route to Y");

  a_eye_pair_update: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    eye_convert_o |-> eye_out_o == $past(q.eye_stage) && q.eye_stage == $past(q.eye_loaded))
    else $error("eye outputs not updated together");

  a_eye_out_hold: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !eye_convert_o |-> $stable(eye_out_o))
    else $error("eye outputs moved without strobe");

  a_no_word_hold: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !main_new && !eye_new |=> $stable(q.tx_loaded) && $stable(q.ctrl) && $stable(q.eye_loaded))
    else $error("destination changed without a completed word");

  // receive side: one conversion per rise, load one strobe later
  a_rx_result_capture: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    rx_convert_o |-> q.rx_result == $past(adc_result_i))
    else $error("conversion result not captured at strobe rise");

  a_rx_result_hold: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !rx_convert_o |-> $stable(q.rx_result))
    else $error("conversion result moved without strobe");

  a_rx_conv_single: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    rx_convert_o |=> !rx_convert_o)
    else $error("receive conversion pulse longer than one cycle");

  a_rx_conv_quiet: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !(q.stb_s2[assp_pkg::STB_RX] && !q.stb_s3[assp_pkg::STB_RX]) |=> !rx_convert_o)
    else $error("receive conversion without strobe rise");

  a_rx_load_primed: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    rx_out_load_o |-> $past(q.rx_state) == assp_pkg::ASSP_RX_PRIMED)
    else $error("output word loaded before a result existed");

  a_rx_first_conv: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    rx_convert_o && $past(q.rx_state) == assp_pkg::ASSP_RX_EMPTY
    |-> !rx_out_load_o && q.rx_state == assp_pkg::ASSP_RX_PRIMED)
    else $error("first receive strobe handled wrongly");

  a_rx_primed_stays: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    q.rx_state == assp_pkg::ASSP_RX_PRIMED |=> q.rx_state == assp_pkg::ASSP_RX_PRIMED)
    else $error("receive pipe lost its primed state");

  a_rx_word_hold: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !rx_out_load_o |-> $stable(rx_out_word_o))
    else $error("output word moved without a load");

  // transmit and eye pipes move only on their own strobe
  a_tx_conv_single: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    tx_convert_o |=> !tx_convert_o)
    else $error("transmit conversion pulse longer than one cycle");

  a_tx_conv_quiet: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !(q.stb_s2[assp_pkg::STB_TX] && !q.stb_s3[assp_pkg::STB_TX]) |=> !tx_convert_o)
    else $error("transmit conversion without strobe rise");

  a_tx_stage_hold: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !tx_convert_o |-> $stable(q.tx_stage))
    else $error("transmit stage moved without strobe");

  a_eye_conv_start: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    q.stb_s2[assp_pkg::STB_EYE] && !q.stb_s3[assp_pkg::STB_EYE] |=> eye_convert_o)
    else $error("eye strobe rise did not start conversion");

  a_eye_conv_single: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    eye_convert_o |=> !eye_convert_o)
    else $error("eye conversion pulse longer than one cycle");

  a_eye_stage_hold: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    !eye_convert_o |-> $stable(q.eye_stage))
    else $error("eye stage moved without strobe");

  // word routing; the eye port wins a clash on the same register
  a_tx_loaded_only: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest != assp_pkg::DEST_TX |=> $stable(q.tx_loaded))
    else $error("transmit register written by another destination");

  a_ctrl_first_decode: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest == assp_pkg::DEST_CTRL_BASE
    |=> q.ctrl[0] == $past(main_word[assp_pkg::DATA_W-1:0]))
    else $error("first control destination not decoded");

  a_ctrl_last_decode: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest == assp_pkg::DEST_CTRL_BASE + 3'(assp_pkg::CTRL_COUNT - 1)
    |=> q.ctrl[assp_pkg::CTRL_COUNT-1] == $past(main_word[assp_pkg::DATA_W-1:0]))
    else $error("last control destination not decoded");

  a_ctrl_only_ctrl: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest < assp_pkg::DEST_CTRL_BASE |=> $stable(q.ctrl))
    else $error("control register written by a data destination");

  a_main_eye_x: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest == assp_pkg::DEST_EYE_X && !eye_new
    |=> q.eye_loaded.x == $past(main_word[assp_pkg::DATA_W-1:0]))
    else $error("main port did not load eye X");

  a_main_eye_y: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest == assp_pkg::DEST_EYE_Y && !eye_new
    |=> q.eye_loaded.y == $past(main_word[assp_pkg::DATA_W-1:0]))
    else $error("main port did not load eye Y");

  a_eye_sel_x: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    eye_new && eye_sel == assp_pkg::EYE_SEL_X
    |=> q.eye_loaded.x == $past(eye_word[assp_pkg::DATA_W-1:0]))
    else $error("eye select did not route to X");

  a_eye_sel_none: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    eye_new && !main_new && eye_sel != assp_pkg::EYE_SEL_X && eye_sel != assp_pkg::EYE_SEL_Y
    |=> $stable(q.eye_loaded))
    else $error("ignored eye select changed a register");

  a_eye_both_ports: assert property (@(posedge clock_i) disable iff (!reset_sync_n)
    main_new && main_dest == assp_pkg::DEST_EYE_X && eye_new && eye_sel != assp_pkg::EYE_SEL_X
    |=> q.eye_loaded.x == $past(main_word[assp_pkg::DATA_W-1:0]))
    else $error("main port eye write lost to the eye port");

endmodule
